// File: inc/supervision_timer_defs.vh
`ifndef SUPERVISION_TIMER_DEFS_VH
`define SUPERVISION_TIMER_DEFS_VH

// ----------------------------------------------------------------------------
// Service key and spans
// ----------------------------------------------------------------------------
`define SERVICE_KEY     8'hA5
`define SPAN_BASE       17'h00008
`define SPAN_SEL_MAX    4'hB

// ----------------------------------------------------------------------------
// Reset values: selects at power-on, enable and window enable at system reset
// ----------------------------------------------------------------------------
`define RST_PERIOD_SEL  4'hB
`define RST_WINDOW_SEL  4'hB
`define RST_EW_SEL      4'hA
`define RST_ENABLE      1'h0
`define RST_WEN         1'h0

`endif

// File: verilog/windowed_supervision_timer.v
`timescale 1ns/10ps
`include "supervision_timer_defs.vh"

module windowed_supervision_timer #(
  parameter CNT_W = 17,
  parameter SEL_W = 4
) (
  // Clock and resets
  input  wire             I_CLK,
  input  wire             I_NRST,
  input  wire             I_NPOR,
  // Counter clock from the low-power oscillator
  input  wire             I_CNT_CLK,
  // Control writes
  input  wire             I_CTRL_WR,
  input  wire             I_CTRL_ENABLE,
  input  wire             I_CTRL_WEN,
  input  wire             I_CTRL_PERSIST,
  // Configuration writes
  input  wire             I_CFG_WR,
  input  wire [SEL_W-1:0] I_CFG_PERIOD,
  input  wire [SEL_W-1:0] I_CFG_WINDOW,
  input  wire [SEL_W-1:0] I_CFG_EW_OFFSET,
  // Interrupt enable and flag
  input  wire             I_IEN_SET,
  input  wire             I_IEN_CLR,
  input  wire             I_FLAG_CLR,
  // Service writes
  input  wire             I_CLEAR_WR,
  input  wire [7:0]       I_CLEAR_DATA,
  // Protection and debug
  input  wire             I_GUARD_WP,
  input  wire             I_DBG_HALT,
  input  wire             I_DBG_RUN,
  input  wire             I_EXT_DBG,
  // Power management
  input  wire             I_PM_BUS_CLK_WR,
  input  wire             I_PM_BUS_CLK_VAL,
  // Outputs
  output wire             O_SYS_RST,
  output wire             O_IRQ,
  output wire             O_WAKE,
  output wire             O_EW_FLAG,
  output wire             O_RUNNING,
  output wire             O_BUS_CLK_EN,
  output wire [CNT_W-1:0] O_COUNT
);

  // --------------------------------------------------------------------------
  // Span decode
  // --------------------------------------------------------------------------
  function [CNT_W-1:0] span;
    input [SEL_W-1:0] sel;
    begin
      // Selects above the top span saturate rather than wrap to a short span
      case (sel)
        4'h0:    span = `SPAN_BASE;
        4'h1:    span = `SPAN_BASE << 4'h1;
        4'h2:    span = `SPAN_BASE << 4'h2;
        4'h3:    span = `SPAN_BASE << 4'h3;
        4'h4:    span = `SPAN_BASE << 4'h4;
        4'h5:    span = `SPAN_BASE << 4'h5;
        4'h6:    span = `SPAN_BASE << 4'h6;
        4'h7:    span = `SPAN_BASE << 4'h7;
        4'h8:    span = `SPAN_BASE << 4'h8;
        4'h9:    span = `SPAN_BASE << 4'h9;
        4'hA:    span = `SPAN_BASE << 4'hA;
        4'hB:    span = `SPAN_BASE << 4'hB;
        default: span = `SPAN_BASE << `SPAN_SEL_MAX;
      endcase
    end
  endfunction

  reg              tick_s1_q;
  reg              tick_s2_q;
  reg              tick_s3_q;
  reg              enable_q;
  reg              wen_q;
  reg              persist_q;
  reg              ew_en_q;
  reg              flag_q;
  reg              rst_q;
  reg              bus_clk_q;
  reg  [SEL_W-1:0] per_sel_q;
  reg  [SEL_W-1:0] win_sel_q;
  reg  [SEL_W-1:0] ew_sel_q;
  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  reg              rst_d;

  wire             tick;
  wire             wr_ok;
  wire             running;
  wire             counting;
  wire [CNT_W-1:0] closed;
  wire [CNT_W-1:0] total;
  wire [CNT_W-1:0] ew_point;
  wire [CNT_W-1:0] cnt_nx;
  wire [CNT_W:0]   total_sum;
  wire [CNT_W:0]   cnt_sum;
  wire             service;
  wire             bad_service;
  wire             timeout;
  wire             ew_hit;

  // --------------------------------------------------------------------------
  // Counter clock crossing
  // --------------------------------------------------------------------------
  // The oscillator is slow, so a rising-edge detect after two stages never misses a tick
  always @(posedge I_CLK)
  begin
    if (!I_NRST)
    begin
      tick_s1_q <= 1'h0;
      tick_s2_q <= 1'h0;
      tick_s3_q <= 1'h0;
    end
    else
    begin
      tick_s1_q <= I_CNT_CLK;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  assign tick = tick_s2_q & ~tick_s3_q;

  // --------------------------------------------------------------------------
  // Write qualification
  // --------------------------------------------------------------------------
  assign wr_ok = bus_clk_q & (~I_GUARD_WP | I_DBG_HALT | I_EXT_DBG);

  // Bus clock is on out of reset and only the power manager changes it
  always @(posedge I_CLK)
  begin
    if (!I_NRST)
    begin
      bus_clk_q <= 1'h1;
    end
    else if (I_PM_BUS_CLK_WR)
    begin
      bus_clk_q <= I_PM_BUS_CLK_VAL;
    end
  end

  // --------------------------------------------------------------------------
  // Control and configuration
  // --------------------------------------------------------------------------
  // Persistence and timing setup survive a system reset; only power-on clears them
  always @(posedge I_CLK)
  begin
    if (!I_NPOR)
    begin
      persist_q <= 1'h0;
      per_sel_q <= `RST_PERIOD_SEL;
      win_sel_q <= `RST_WINDOW_SEL;
      ew_sel_q  <= `RST_EW_SEL;
    end
    else
    begin
      if (I_CTRL_WR && wr_ok && !enable_q && !persist_q && I_CTRL_PERSIST)
      begin
        persist_q <= 1'h1;
      end
      if (I_CFG_WR && wr_ok && !enable_q && !persist_q)
      begin
        per_sel_q <= I_CFG_PERIOD;
        win_sel_q <= I_CFG_WINDOW;
        ew_sel_q  <= I_CFG_EW_OFFSET;
      end
    end
  end

  always @(posedge I_CLK)
  begin
    if (!I_NRST)
    begin
      enable_q <= `RST_ENABLE;
      wen_q    <= `RST_WEN;
      ew_en_q  <= 1'h0;
    end
    else
    begin
      if (I_CTRL_WR && wr_ok)
      begin
        // Disabling is refused while persistent run is set
        if (!persist_q)
        begin
          enable_q <= I_CTRL_ENABLE;
        end
        if (!enable_q && !persist_q)
        begin
          wen_q <= I_CTRL_WEN;
        end
      end
      if (I_IEN_SET && wr_ok)
      begin
        ew_en_q <= 1'h1;
      end
      else if (I_IEN_CLR && wr_ok)
      begin
        ew_en_q <= 1'h0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  assign running  = enable_q | persist_q;
  // Sleep state is not an input at all, so counting carries on through it
  assign counting = running & (~I_DBG_HALT | I_DBG_RUN);
  assign closed   = wen_q ? span(win_sel_q) : {CNT_W{1'b0}};
  // Largest pair of spans still fits CNT_W, so the dropped carry is always zero
  assign total_sum = {1'h0, closed} + {1'h0, span(per_sel_q)};
  assign total     = total_sum[CNT_W-1:0];
  assign ew_point  = wen_q ? closed : span(ew_sel_q);
  assign cnt_sum   = {1'h0, cnt_q} + {{CNT_W{1'b0}}, 1'b1};
  assign cnt_nx    = cnt_sum[CNT_W-1:0];

  // Service writes are not gated by debug halt: software may still service
  assign service     = I_CLEAR_WR & wr_ok & running;
  assign bad_service = service & ((I_CLEAR_DATA != `SERVICE_KEY) | (cnt_q < closed));
  assign timeout     = counting & tick & (cnt_nx >= total);
  assign ew_hit      = counting & tick & (cnt_nx == ew_point);

  always @*
  begin
    cnt_d = cnt_q;
    rst_d = 1'b0;
    if (!running)
    begin
      cnt_d = {CNT_W{1'b0}};
    end
    else if (bad_service || timeout)
    begin
      cnt_d = {CNT_W{1'b0}};
      rst_d = 1'b1;
    end
    else if (service)
    begin
      cnt_d = {CNT_W{1'b0}};
    end
    else if (counting && tick)
    begin
      cnt_d = cnt_nx;
    end
  end

  always @(posedge I_CLK)
  begin
    if (!I_NRST)
      cnt_q <= {CNT_W{1'b0}};
    else
      cnt_q <= cnt_d;
  end

  // --------------------------------------------------------------------------
  // Reset request
  // --------------------------------------------------------------------------
  // Registered so the request is a clean one-cycle pulse with no glitches
  always @(posedge I_CLK)
  begin
    if (!I_NRST)
      rst_q <= 1'h0;
    else
      rst_q <= rst_d;
  end

  // --------------------------------------------------------------------------
  // Early warning flag
  // --------------------------------------------------------------------------
  // The flag is set regardless of enable; a new event beats a clear in the same cycle
  always @(posedge I_CLK)
  begin
    if (!I_NRST)
    begin
      flag_q <= 1'h0;
    end
    else if (ew_hit && !service)
    begin
      flag_q <= 1'h1;
    end
    else if (I_FLAG_CLR && bus_clk_q)
    begin
      flag_q <= 1'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign O_SYS_RST    = rst_q;
  assign O_IRQ        = flag_q & ew_en_q;
  assign O_WAKE       = flag_q & ew_en_q;
  assign O_EW_FLAG    = flag_q;
  assign O_RUNNING    = running;
  assign O_BUS_CLK_EN = bus_clk_q;
  assign O_COUNT      = cnt_q;

endmodule // windowed_supervision_timer

// File: test/windowed_supervision_timer_chk.sv
`timescale 1ns/10ps
// ----------
// Port checker
// ----------
module windowed_supervision_timer_chk #(
  parameter CNT_W = 17
) (
  input logic             I_CLK,
  input logic             I_NRST,
  input logic             I_CLEAR_WR,
  input logic [7:0]       I_CLEAR_DATA,
  input logic             I_GUARD_WP,
  input logic             I_DBG_HALT,
  input logic             I_DBG_RUN,
  input logic             I_EXT_DBG,
  input logic             I_FLAG_CLR,
  input logic             O_SYS_RST,
  input logic             O_IRQ,
  input logic             O_WAKE,
  input logic             O_EW_FLAG,
  input logic             O_RUNNING,
  input logic             O_BUS_CLK_EN,
  input logic [CNT_W-1:0] O_COUNT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // Service writes the block must act on
  wire taken = I_CLEAR_WR & O_RUNNING & O_BUS_CLK_EN & (~I_GUARD_WP | I_DBG_HALT | I_EXT_DBG);
  sequence s_bad;
    taken && I_CLEAR_DATA != 8'hA5;
  endsequence
  // Three cycles is enough to cover the tick pipeline
  sequence s_frozen;
    (I_DBG_HALT && !I_DBG_RUN && !I_CLEAR_WR)[*3];
  endsequence
  sequence s_pulse_end;
    O_COUNT == 'h0 ##1 !O_SYS_RST;
  endsequence
  a_bad_key_reset: assert property (s_bad |=> O_SYS_RST)
    else $error("bad key gave no reset");
  a_service_restart: assert property (taken |=> O_COUNT == 'h0)
    else $error("service did not restart count");
  a_reset_pulse: assert property (O_SYS_RST |-> s_pulse_end)
    else $error("reset pulse malformed");
  a_count_step: assert property ($changed(O_COUNT) |-> O_COUNT == 'h0 || O_COUNT == $past(O_COUNT) + 'h1)
    else $error("count jumped");
  a_halt_freeze: assert property (s_frozen |-> $stable(O_COUNT))
    else $error("count moved in debug halt");
  a_irq_flag: assert property (O_IRQ |-> O_EW_FLAG)
    else $error("request without flag");
  a_flag_hold: assert property (O_EW_FLAG && !I_FLAG_CLR |=> O_EW_FLAG)
    else $error("flag dropped");
  a_wake_irq: assert property (O_WAKE == O_IRQ)
    else $error("wake differs from request");
  a_bus_clk_init: assert property ($rose(I_NRST) |-> O_BUS_CLK_EN)
    else $error("bus clock off after reset");
endmodule // windowed_supervision_timer_chk

bind windowed_supervision_timer windowed_supervision_timer_chk #(.CNT_W(CNT_W)) i_chk (.*);

// File: test/windowed_supervision_timer_tb.sv
`timescale 1ns/10ps
module windowed_supervision_timer_tb;
  // ----------
  // Signals
  // ----------
  logic I_CLK = 0, I_NRST = 0, I_NPOR = 0, I_CNT_CLK = 0, I_CTRL_WR = 0, I_CTRL_ENABLE = 0;
  logic I_CTRL_WEN = 0, I_CTRL_PERSIST = 0, I_CFG_WR = 0, I_IEN_SET = 0, I_IEN_CLR = 0;
  logic I_FLAG_CLR = 0, I_CLEAR_WR = 0, I_GUARD_WP = 0, I_DBG_HALT = 0, I_DBG_RUN = 0;
  logic I_EXT_DBG = 0, I_PM_BUS_CLK_WR = 0, I_PM_BUS_CLK_VAL = 0;
  logic [3:0] I_CFG_PERIOD = 4'h0, I_CFG_WINDOW = 4'h0, I_CFG_EW_OFFSET = 4'h0;
  logic [7:0] I_CLEAR_DATA = 8'h00;
  wire O_SYS_RST, O_IRQ, O_WAKE, O_EW_FLAG, O_RUNNING, O_BUS_CLK_EN;
  wire [16:0] O_COUNT;
  int error_cnt = 0, compares = 0, rsts = 0, cycles = 0, r0;
  windowed_supervision_timer i_windowed_supervision_timer (.*);
  always #12.5 I_CLK = ~I_CLK;
  // Count reset pulses; the cycle ceiling cuts a hang short
  always @(posedge I_CLK)
  begin
    rsts <= rsts + (O_SYS_RST === 1'h1);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  // ----------
  // Helpers
  // ----------
  task chk(input string n, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Slow tick: eight system cycles leave room for the sync stages
  task tick(input int n);
    repeat (n)
    begin
      @(negedge I_CLK) I_CNT_CLK = 1;
      repeat (3) @(negedge I_CLK);
      I_CNT_CLK = 0;
      repeat (4) @(negedge I_CLK);
    end
  endtask
  task ctrl(input logic en, input logic wen, input logic per);
    @(negedge I_CLK) {I_CTRL_WR, I_CTRL_ENABLE, I_CTRL_WEN, I_CTRL_PERSIST} = {1'h1, en, wen, per};
    @(negedge I_CLK) I_CTRL_WR = 0;
  endtask
  task svc(input logic [7:0] d);
    @(negedge I_CLK) {I_CLEAR_WR, I_CLEAR_DATA} = {1'h1, d};
    @(negedge I_CLK) I_CLEAR_WR = 0;
    @(negedge I_CLK);
  endtask
  task pm(input logic v);
    @(negedge I_CLK) {I_PM_BUS_CLK_WR, I_PM_BUS_CLK_VAL} = {1'h1, v};
    @(negedge I_CLK) I_PM_BUS_CLK_WR = 0;
  endtask
  // ----------
  // Scenarios
  // ----------
  task t_reset;
    chk("bus_clk_en", 1, O_BUS_CLK_EN);
    pm(0);
    chk("bus_clk_en", 0, O_BUS_CLK_EN);
    ctrl(1, 0, 0);
    chk("running", 0, O_RUNNING);
    pm(1);
    @(negedge I_CLK) {I_CFG_WR, I_CFG_PERIOD} = {1'h1, 4'h1};
    @(negedge I_CLK) {I_CFG_WR, I_IEN_SET} = 2'h1;
    @(negedge I_CLK) I_IEN_SET = 0;
  endtask
  task t_normal;
    r0 = rsts;
    ctrl(1, 0, 0);
    tick(7);
    chk("flag", 0, O_EW_FLAG);
    tick(1);
    chk("irq", 1, O_IRQ);
    chk("wake", 1, O_WAKE);
    @(negedge I_CLK) I_FLAG_CLR = 1;
    @(negedge I_CLK) I_FLAG_CLR = 0;
    chk("flag", 0, O_EW_FLAG);
    tick(7);
    chk("rsts", r0, rsts);
    tick(1);
    chk("rsts", r0 + 1, rsts);
    ctrl(0, 0, 0);
  endtask
  task t_service;
    @(negedge I_CLK) {I_CFG_WR, I_CFG_PERIOD} = {1'h1, 4'h0};
    @(negedge I_CLK) I_CFG_WR = 0;
    ctrl(1, 0, 0);
    r0 = rsts;
    tick(5);
    svc(8'hA5);
    chk("count", 0, O_COUNT);
    tick(5);
    I_GUARD_WP = 1;
    svc(8'hA5);
    chk("count", 5, O_COUNT);
    I_EXT_DBG = 1;
    svc(8'hA5);
    chk("count", 0, O_COUNT);
    I_EXT_DBG = 0;
    tick(3);
    I_DBG_HALT = 1;
    tick(2);
    chk("count", 3, O_COUNT);
    svc(8'hA5);
    chk("count", 0, O_COUNT);
    I_DBG_RUN = 1;
    tick(1);
    chk("count", 1, O_COUNT);
    {I_DBG_HALT, I_DBG_RUN, I_GUARD_WP} = 3'h0;
    chk("rsts", r0, rsts);
    svc(8'h5A);
    chk("rsts", r0 + 1, rsts);
    ctrl(0, 0, 0);
  endtask
  task t_window;
    ctrl(1, 1, 0);
    r0 = rsts;
    tick(3);
    svc(8'hA5);
    chk("rsts", r0 + 1, rsts);
    tick(7);
    chk("flag", 0, O_EW_FLAG);
    tick(1);
    chk("flag", 1, O_EW_FLAG);
    @(negedge I_CLK) I_IEN_CLR = 1;
    @(negedge I_CLK) I_IEN_CLR = 0;
    chk("irq", 0, O_IRQ);
    chk("flag", 1, O_EW_FLAG);
    tick(2);
    svc(8'hA5);
    chk("rsts", r0 + 1, rsts);
  endtask
  task t_persist;
    ctrl(0, 0, 0);
    chk("running", 0, O_RUNNING);
    ctrl(0, 0, 1);
    ctrl(0, 0, 0);
    I_NRST = 0;
    repeat (3) @(negedge I_CLK);
    chk("running", 1, O_RUNNING);
    I_NPOR = 0;
    repeat (3) @(negedge I_CLK);
    chk("running", 0, O_RUNNING);
  endtask
  task end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge I_CLK);
    {I_NRST, I_NPOR} = 2'h3;
    t_reset();
    t_normal();
    t_service();
    t_window();
    t_persist();
    end_sim();
  end
endmodule // windowed_supervision_timer_tb
